// [design/sfcr_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sfcr_cfg.svh"

// How it works
// [R1] Boot dummy code 0000 behaves as 1111
// [R2] Default dummy code gives count for 108 MHz
// [R3] Host picks enough dummy clocks for speed
// [R4] Boot read field selects direct execute mode (XIP_ALWAYS set to 1 forces it on)
// [R5] Boot bit 4 enables hold/reset pin
// [R6] Boot bits 3/2 pick quad/dual protocol
// [R7] Boot word leaves factory all ones (reset loads 16'hffef when HOLD_FITTED is 0)
// [R8] Boot word via own commands, rules power-on
// [R9] Runtime dummy field, same coding as boot
// [R10] Runtime bit 3 toggles execute mode (held on when XIP_ALWAYS is 1)
// [R11] Runtime wrap field picks 16/32/64/continuous
// [R12] Wrapped reads roll within aligned block
// [R13] Runtime writes act immediately, own commands
// [R14] Reload working settings from boot word
// [R15] Busy flag high during boot word write
// [R16] Host sets write enable, polls busy
// [R17] Reserved bits ignored, runtime bit 2 zero
module sfcr_core
	import sfcr_pkg::*;
#(
	parameter bit HOLD_FITTED = 1'b1,
	parameter bit XIP_ALWAYS  = 1'b0
) (
	// System
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Serial link
	input  wire logic         sclk,
	input  wire logic         cs_n,
	input  wire logic         mosi,
	output logic              miso,
	output logic              miso_oe,
	// Device control
	input  wire logic         boot_reload,
	input  wire logic         write_enable_latch,
	output logic              write_in_progress,
	output sfcr_pkg::sfcr_work_s work_cfg,
	// Array read address
	input  wire logic         addr_load,
	input  wire logic [23:0]  addr_in,
	input  wire logic         addr_step,
	output logic [23:0]       read_addr
);
	import sfcr_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] dummy_count(input logic [3:0] code);
		dummy_count = (code == 4'h0 || code == 4'hf) ? `DUMMY_DEFAULT : code; // [R1] [R2] [R9]
	endfunction

	function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic [1:0] w);
		logic [23:0] m;
		m = 24'hffffff;
		case (w)
			`WRAP_16: m = 24'h00000f;
			`WRAP_32: m = 24'h00001f;
			`WRAP_64: m = 24'h00003f;
			default:  m = 24'hffffff;
		endcase
		wrap_next = (a & ~m) | ((a + 24'h000001) & m); // [R11] [R12]
	endfunction

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	sfcr_lnk_s  l_ff, nxt_l;
	sfcr_post_s p_ff, nxt_p;
	sfcr_core_s c_ff, nxt_c;
	logic       lrst_n;
	logic [15:0] rd;

	// Frame logic ends with the frame: a raised select clears it without any clock
	assign lrst_n = arst_n & ~cs_n;

	always_comb begin
		nxt_l = l_ff;
		nxt_p = p_ff;
		rd = 16'h0000;
		nxt_p.m1 = {c_ff.wip, c_ff.vol, c_ff.nv};
		nxt_p.m2 = p_ff.m1;
		nxt_l.sh = {l_ff.sh[14:0], mosi};
		nxt_l.cnt = l_ff.cnt + 5'h01;
		nxt_l.miso = l_ff.tx[15];
		nxt_l.tx = {l_ff.tx[14:0], 1'b0};
		if (!l_ff.have_op) begin
			if (l_ff.cnt == `OP_LEN) begin
				nxt_l.op = {l_ff.sh[6:0], mosi};
				nxt_l.have_op = 1'b1;
				nxt_l.cnt = 5'h00;
				case (nxt_l.op)
					`OP_RD_NV:   rd = p_ff.m2[15:0]; // [R8]
					`OP_RD_VOL:  rd = {p_ff.m2[23:16], 8'h00}; // [R13]
					`OP_RD_STAT: rd = {7'h00, p_ff.m2[24], 8'h00}; // [R15]
					default:     rd = 16'h0000;
				endcase
				nxt_l.miso = rd[15];
				nxt_l.tx = {rd[14:0], 1'b0};
				nxt_l.oe = (nxt_l.op == `OP_RD_NV) || (nxt_l.op == `OP_RD_VOL)
					|| (nxt_l.op == `OP_RD_STAT);
			end
		end else if (!l_ff.done && ((l_ff.op == `OP_WR_NV && l_ff.cnt == `NV_LEN)
				|| (l_ff.op == `OP_WR_VOL && l_ff.cnt == `OP_LEN))) begin
			// Word is held here until the next write, so the core reads it calmly
			nxt_l.done = 1'b1;
			nxt_p.wdat = {l_ff.sh[14:0], mosi};
			nxt_p.wsel = (l_ff.op == `OP_WR_NV);
			nxt_p.tog = ~p_ff.tog;
		end
	end

	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			l_ff <= '0;
		end else begin
			l_ff <= nxt_l;
		end
	end

	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			p_ff <= '0;
		end else begin
			p_ff <= nxt_p;
		end
	end

	assign miso = l_ff.miso;
	assign miso_oe = l_ff.oe;

	// ----------------------------------------
	// Core domain
	// ----------------------------------------
	logic       evt;
	logic       nv_evt;
	logic       vol_evt;
	logic [7:0] vw;

	assign evt = c_ff.ts[1] ^ c_ff.ts[2];
	assign nv_evt = evt && p_ff.wsel && write_enable_latch && !c_ff.wip; // [R16]
	assign vol_evt = evt && !p_ff.wsel;
	assign vw = p_ff.wdat[7:0];

	always_comb begin
		nxt_c = c_ff;
		nxt_c.ts = {c_ff.ts[1:0], p_ff.tog};
		if (c_ff.busy != 16'h0000) begin
			nxt_c.busy = c_ff.busy - 16'h0001;
			if (c_ff.busy == 16'h0001) begin
				// Reserved bits keep their old value
				nxt_c.nv = (c_ff.pend & `NV_WR_MASK) | (c_ff.nv & ~`NV_WR_MASK); // [R8] [R17]
			end
		end
		if (nv_evt) begin
			nxt_c.busy = `NVW_CYCLES; // [R15]
			nxt_c.pend = p_ff.wdat;
		end
		if (vol_evt) begin
			nxt_c.vol = {vw[`VOL_DUMMY], vw[`VOL_XIP], 1'b0, vw[`VOL_WRAP]}; // [R17]
			nxt_c.work.dummy_code = vw[`VOL_DUMMY]; // [R13] [R14]
			nxt_c.work.dummy_cycles = dummy_count(vw[`VOL_DUMMY]); // [R9]
			nxt_c.work.execute_in_place_mode = XIP_ALWAYS | ~vw[`VOL_XIP]; // [R10]
			nxt_c.work.wrap = vw[`VOL_WRAP]; // [R11]
		end
		if (!c_ff.loaded || boot_reload) begin
			nxt_c.loaded = 1'b1;
			nxt_c.work.dummy_code = c_ff.nv[`NV_DUMMY]; // [R14]
			nxt_c.work.dummy_cycles = dummy_count(c_ff.nv[`NV_DUMMY]); // [R1]
			nxt_c.work.xip_read = c_ff.nv[`NV_XIPM];
			// Reserved read codes leave execute mode off unless XIP_ALWAYS is 1
			nxt_c.work.execute_in_place_mode = XIP_ALWAYS
				| (c_ff.nv[`NV_XIPM] <= `XIP_MAX); // [R4]
			nxt_c.work.drive = c_ff.nv[`NV_DRIVE];
			nxt_c.work.hold_en = c_ff.nv[`NV_HOLD]; // [R5]
			nxt_c.work.proto = !c_ff.nv[`NV_QUAD] ? PROTO_QUAD
				: (!c_ff.nv[`NV_DUAL] ? PROTO_DUAL : PROTO_EXT); // [R6]
			nxt_c.work.wrap = 2'h3;
			nxt_c.vol = {c_ff.nv[`NV_DUMMY], c_ff.nv[`NV_XIPM] == `XIP_OFF, 3'h3};
		end
		if (addr_load) begin
			nxt_c.addr = addr_in; // [R12]
		end else if (addr_step) begin
			nxt_c.addr = wrap_next(c_ff.addr, c_ff.work.wrap); // [R12]
		end
		nxt_c.wip = (nxt_c.busy != 16'h0000); // [R15]
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			c_ff <= '0;
			c_ff.nv <= HOLD_FITTED ? `NV_FACTORY : `NV_NOHOLD; // [R7]
		end else begin
			c_ff <= nxt_c;
		end
	end

	assign write_in_progress = c_ff.wip;
	assign work_cfg = c_ff.work;
	assign read_addr = c_ff.addr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_dummy_default: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
		c_ff.loaded && (c_ff.work.dummy_code == 4'h0 || c_ff.work.dummy_code == 4'hf)
		|-> c_ff.work.dummy_cycles == `DUMMY_DEFAULT)
		else $error("dummy default count wrong");

	a_boot_xip: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
		boot_reload && !vol_evt |=> c_ff.work.execute_in_place_mode
		== (XIP_ALWAYS | ($past(c_ff.nv[11:9]) <= 3'h4)))
		else $error("boot execute mode wrong");

	a_boot_hold: assert property (@(posedge clk) disable iff (!arst_n) // [R5]
		boot_reload |=> c_ff.work.hold_en == $past(c_ff.nv[4]))
		else $error("hold enable not loaded");

	a_boot_quad: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
		boot_reload && !c_ff.nv[3] |=> c_ff.work.proto == PROTO_QUAD)
		else $error("quad protocol not selected");

	a_vol_dummy: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
		vol_evt && !boot_reload && c_ff.loaded
		|=> c_ff.work.dummy_code == $past(vw[7:4]) && c_ff.vol[2] == 1'b0)
		else $error("runtime write not applied");

	a_wrap_16: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
		addr_step && !addr_load && c_ff.work.wrap == 2'h0 && c_ff.addr[3:0] == 4'hf
		|=> c_ff.addr == {$past(c_ff.addr[23:4]), 4'h0})
		else $error("16 byte wrap wrong");

	a_wip_hold: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
		nv_evt |=> write_in_progress [*8])
		else $error("busy flag dropped early");

	a_nv_commit: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
		c_ff.nv != $past(c_ff.nv) |-> $past(c_ff.busy) == 16'h0001)
		else $error("boot word changed outside write");

	a_nv_rsvd: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
		c_ff.busy == 16'h0001 |=> c_ff.nv[5] == $past(c_ff.nv[5])
		&& c_ff.nv[1:0] == $past(c_ff.nv[1:0]))
		else $error("reserved boot bits written");

	a_boot_dual: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
		(boot_reload || !c_ff.loaded) && c_ff.nv[3] && !c_ff.nv[2]
		|=> c_ff.work.proto == PROTO_DUAL)
		else $error("dual protocol not selected");

	a_boot_ext: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
		(boot_reload || !c_ff.loaded) && c_ff.nv[3] && c_ff.nv[2]
		|=> c_ff.work.proto == PROTO_EXT)
		else $error("extended protocol not kept");

	a_boot_dcode: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
		boot_reload |=> c_ff.work.dummy_code == $past(c_ff.nv[15:12]))
		else $error("boot dummy code not loaded");

	a_dcyc_nonzero: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
		c_ff.loaded |-> c_ff.work.dummy_cycles != 4'h0)
		else $error("dummy count of zero");

	a_vol_xip: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
		vol_evt && !boot_reload && c_ff.loaded
		|=> c_ff.work.execute_in_place_mode == (XIP_ALWAYS | !$past(vw[3])))
		else $error("runtime execute mode wrong");

	a_vol_wrap: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
		vol_evt && !boot_reload && c_ff.loaded |=> c_ff.work.wrap == $past(vw[1:0]))
		else $error("runtime wrap not applied");

	a_vol_rsvd: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
		c_ff.vol[2] == 1'b0)
		else $error("runtime bit 2 not zero");

	a_addr_load: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
		addr_load |=> c_ff.addr == $past(addr_in))
		else $error("start address not taken");

	a_wrap_32: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
		addr_step && !addr_load && c_ff.work.wrap == 2'h1 && c_ff.addr[4:0] == 5'h1f
		|=> c_ff.addr == {$past(c_ff.addr[23:5]), 5'h00})
		else $error("32 byte wrap wrong");

	a_wrap_64: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
		addr_step && !addr_load && c_ff.work.wrap == 2'h2 && c_ff.addr[5:0] == 6'h3f
		|=> c_ff.addr == {$past(c_ff.addr[23:6]), 6'h00})
		else $error("64 byte wrap wrong");

	a_seq_step: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
		addr_step && !addr_load && c_ff.work.wrap == 2'h3
		|=> c_ff.addr == $past(c_ff.addr) + 24'h000001)
		else $error("continuous read step wrong");

	a_wip_clear: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
		c_ff.busy == 16'h0001 |=> !write_in_progress)
		else $error("busy flag stuck after write");

	a_nv_refuse: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
		evt && p_ff.wsel && !write_enable_latch && c_ff.busy == 16'h0000
		|=> c_ff.busy == 16'h0000)
		else $error("unlatched boot write started");

	a_oe_read: assert property (@(posedge sclk) disable iff (!lrst_n) // [R8]
		l_ff.oe |-> l_ff.have_op)
		else $error("link driven before opcode");

endmodule
`default_nettype wire

// [design/sfcr_cfg.svh]
`ifndef SFCR_CFG_SVH
`define SFCR_CFG_SVH

// ----------------------------------------
// Boot word layout and values
// ----------------------------------------
`define NV_FACTORY    16'hffff
`define NV_NOHOLD     16'hffef
`define NV_WR_MASK    16'hffdc
`define NV_DUMMY      15:12
`define NV_XIPM       11:9
`define NV_DRIVE      8:6
`define NV_HOLD       4
`define NV_QUAD       3
`define NV_DUAL       2

// ----------------------------------------
// Runtime word layout and values
// ----------------------------------------
`define VOL_DUMMY     7:4
`define VOL_XIP       3
`define VOL_RSVD      2
`define VOL_WRAP      1:0
`define WRAP_16       2'h0
`define WRAP_32       2'h1
`define WRAP_64       2'h2
`define XIP_OFF       3'h7
`define XIP_MAX       3'h4
`define DUMMY_DEFAULT 4'ha

// ----------------------------------------
// Link commands and counts
// ----------------------------------------
`define OP_RD_NV      8'h31
`define OP_WR_NV      8'h32
`define OP_RD_VOL     8'h33
`define OP_WR_VOL     8'h34
`define OP_RD_STAT    8'h35
`define OP_LEN        5'h07
`define NV_LEN        5'h0f
`define NVW_CYCLES    16'h07d0

`endif

// [design/sfcr_pkg.sv]
package sfcr_pkg;

	typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} sfcr_proto_e;

	typedef struct packed {
		logic [3:0]  dummy_code;
		logic [3:0]  dummy_cycles;
		logic        execute_in_place_mode;
		logic [2:0]  xip_read;
		logic [2:0]  drive;
		logic        hold_en;
		sfcr_proto_e proto;
		logic [1:0]  wrap;
	} sfcr_work_s;

	typedef struct packed {
		logic [7:0]  op;
		logic [15:0] sh;
		logic [4:0]  cnt;
		logic        have_op;
		logic        done;
		logic [15:0] tx;
		logic        miso;
		logic        oe;
	} sfcr_lnk_s;

	typedef struct packed {
		logic [15:0] wdat;
		logic        wsel;
		logic        tog;
		logic [24:0] m1;
		logic [24:0] m2;
	} sfcr_post_s;

	typedef struct packed {
		logic [2:0]  ts;
		logic        loaded;
		logic [15:0] nv;
		logic [7:0]  vol;
		logic [15:0] busy;
		logic [15:0] pend;
		logic        wip;
		sfcr_work_s  work;
		logic [23:0] addr;
	} sfcr_core_s;

endpackage

// [verif/sfcr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module sfcr_host (
	// Link
	output logic        sclk,
	output logic        cs_n,
	output logic        mosi,
	input  wire logic   miso,
	// Read result
	output logic [15:0] rd_data,
	output logic        rd_valid
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		rd_data = 16'h0;
		rd_valid = 1'b0;
	end
	// --------------------------------
	// One command per frame
	// --------------------------------
	// Clock stands still outside frames; opcode and data MSB first
	task automatic xfer(input logic [7:0] op, input logic [15:0] dat, input int n, input bit rd);
		logic [23:0] sh;
		sh = {op, dat};
		rd_data = 16'h0;
		cs_n = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			mosi = sh[23 - i];
			#6;
			// Sample before the rise, so no race with the launch
			if (i >= 8)
				rd_data = {rd_data[14:0], miso};
			sclk = 1'b1;
			#6;
			sclk = 1'b0;
		end
		#6;
		cs_n = 1'b1;
		// Released line shows no stale value
		mosi = ~mosi;
		rd_valid = rd;
		#1;
		rd_valid = 1'b0;
		#12;
	endtask
endmodule
`default_nettype wire

// [verif/tb_serial_flash_config_registers.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sfcr_cfg.svh"
module tb_serial_flash_config_registers;
	import sfcr_pkg::*;
	logic        clk, arst_n, sclk, cs_n, mosi, miso, boot_reload, wel, wip;
	logic        addr_load, addr_step, rd_valid, miso_oe;
	logic [23:0] addr_in, read_addr, a, e, blk;
	logic [15:0] rd_data, w, nvx;
	logic [7:0]  v;
	logic [3:0]  dc;
	logic [1:0]  ep;
	sfcr_work_s  work_cfg;
	logic [15:0] exp_q[$];
	int          fails, compares, n, oe_cnt;

	sfcr_core i_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .boot_reload(boot_reload), .write_enable_latch(wel),
		.write_in_progress(wip), .work_cfg(work_cfg), .addr_load(addr_load),
		.addr_in(addr_in), .addr_step(addr_step), .read_addr(read_addr));
	sfcr_host i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.rd_data(rd_data), .rd_valid(rd_valid));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Frame gap keeps writes well apart
	task automatic frame(input logic [7:0] op, input logic [15:0] d, input int nb, input bit rd);
		int n0;
		n0 = oe_cnt;
		if (rd)
			exp_q.push_back(d);
		i_host.xfer(op, rd ? 16'h0 : d, nb, rd);
		check("oe", 24'(oe_cnt - n0), rd ? 24'(nb + 1) : 24'h0);
		repeat (8) @(negedge clk);
	endtask

	// Drive enable counted per link clock; reads drive from the eighth rise to the frame end
	always @(negedge sclk) begin
		if (miso_oe === 1'b1)
			oe_cnt++;
	end

	always @(posedge rd_valid) check("rd", rd_data, exp_q.pop_front());

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end

	initial begin
		{arst_n, boot_reload, wel, addr_load, addr_step} = 5'h0;
		addr_in = 24'h0;
		fails = 0;
		compares = 0;
		oe_cnt = 0;
		void'($urandom(83170));
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		check("dummy", work_cfg.dummy_cycles, 4'ha);
		check("hold", work_cfg.hold_en, 1'b1);
		check("proto", work_cfg.proto, PROTO_EXT);
		check("xip", work_cfg.xip_read, 3'h7);
		frame(`OP_RD_NV, 16'hffff, 16, 1'b1);
		frame(`OP_RD_VOL, 16'h00fb, 8, 1'b1);
		$display("test defaults done");
		for (int k = 0; k < 2; k++) begin
			v = k ? 8'($urandom) : 8'h00;
			frame(`OP_WR_VOL, {v, 8'h00}, 8, 1'b0);
			check("dcode", work_cfg.dummy_code, v[7:4]);
			if (v[7:4] == 4'h0 || v[7:4] == 4'hf)
				check("dcyc", work_cfg.dummy_cycles, 4'ha);
			else
				check("dcyc", work_cfg.dummy_cycles, v[7:4]);
			check("xen", work_cfg.execute_in_place_mode, !v[3]);
			check("wrap", work_cfg.wrap, v[1:0]);
			frame(`OP_RD_VOL, {8'h00, v & 8'hfb}, 8, 1'b1);
		end
		$display("test runtime done");
		for (int m = 0; m < 4; m++) begin
			// Dummy code ten suits every read variant at full speed
			frame(`OP_WR_VOL, {6'h2a, m[1:0], 8'h00}, 8, 1'b0);
			a = {18'($urandom), 6'h3d};
			addr_in = a;
			addr_load = 1'b1;
			@(negedge clk);
			addr_load = 1'b0;
			addr_step = 1'b1;
			repeat (3) @(negedge clk);
			addr_step = 1'b0;
			@(negedge clk);
			blk = 24'h10 << m;
			e = (m == 3) ? a + 24'h3 : (a & ~(blk - 24'h1)) | ((a + 24'h3) & (blk - 24'h1));
			check("addr", read_addr, e);
		end
		$display("test wrap done");
		nvx = `NV_FACTORY;
		// First pass both protocol bits low, second pass dual only
		for (int j = 0; j < 2; j++) begin
			w = 16'($urandom);
			w[3:2] = j ? 2'h2 : 2'h0;
			frame(`OP_WR_NV, w, 16, 1'b0);
			check("wip_off", wip, 1'b0);
			frame(`OP_RD_NV, nvx, 16, 1'b1);
			wel = 1'b1;
			i_host.xfer(`OP_WR_NV, w, 16, 1'b0);
			n = 0;
			while (wip !== 1'b1 && n < 40) begin
				@(negedge clk);
				n++;
			end
			check("wip_on", wip, 1'b1);
			frame(`OP_RD_STAT, 16'h0001, 8, 1'b1);
			n = 0;
			while (wip === 1'b1 && n < 3000) begin
				@(negedge clk);
				n++;
			end
			check("wip_end", wip, 1'b0);
			wel = 1'b0;
			frame(`OP_RD_STAT, 16'h0000, 8, 1'b1);
			nvx = (w & `NV_WR_MASK) | (nvx & ~`NV_WR_MASK);
			frame(`OP_RD_NV, nvx, 16, 1'b1);
			boot_reload = 1'b1;
			@(negedge clk);
			boot_reload = 1'b0;
			repeat (2) @(negedge clk);
			ep = !w[3] ? PROTO_QUAD : (!w[2] ? PROTO_DUAL : PROTO_EXT);
			dc = (w[15:12] == 4'h0 || w[15:12] == 4'hf) ? `DUMMY_DEFAULT : w[15:12];
			check("bdcode", work_cfg.dummy_code, w[15:12]);
			check("bdcyc", work_cfg.dummy_cycles, dc);
			check("bxip", work_cfg.xip_read, w[11:9]);
			check("bhold", work_cfg.hold_en, w[4]);
			check("bproto", work_cfg.proto, ep);
			frame(`OP_RD_VOL, {8'h00, w[15:12], w[11:9] == 3'h7, 3'h3}, 8, 1'b1);
		end
		$display("test boot word done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
